// ===== hw/pcfg_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - static config only during fundamental reset sequence
// - eeprom multi-partition boot: all disabled, unattached
// - port control write attaches port as written
// - full retrain restarts link from Detect
// - disable ports with no-action; partition ignored
// - no-action change keeps registers; down link retrains
module pcfg_top (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire logic [3:0]                  switchModePin,
  input  wire logic                        fundResetPinN,
  input  wire logic [pcfg_pkg::NPORT-1:0]  partnerPresent,
  input  wire logic [pcfg_pkg::NPART-1:0]  partResetPinN,
  output var  logic [pcfg_pkg::NPORT-1:0]  portLinkUp,
  output var  logic [pcfg_pkg::NPART-1:0]  partActive,
  output var  logic [pcfg_pkg::NPART-1:0]  partResetActive,
  output var  logic                        configOpen
);
  logic [3:0]                 modeS1_q, modeS2_q, switch_mode_vector_q;
  logic                       frS1_q, frS2_q;
  logic [pcfg_pkg::NPORT-1:0] prsS1_q, prsS2_q;
  logic [pcfg_pkg::NPART-1:0] prtS1_q, prtS2_q;
  logic                       busy_q, rstEn_q, drainDone;
  logic [1:0]                 partSt_q  [pcfg_pkg::NPART];
  logic [2:0]                 portMode_q [pcfg_pkg::NPORT];
  logic [pcfg_pkg::PSW-1:0]   portPart_q [pcfg_pkg::NPORT];
  logic [2:0]                 portOma_q  [pcfg_pkg::NPORT];
  logic [pcfg_pkg::TMR_W-1:0] tmr_q      [pcfg_pkg::NTMR];
  logic [19:0]                cap_q      [pcfg_pkg::NPORT];
  logic [pcfg_pkg::NPORT-1:0] retrain_q, modeChg_q;
  pcfg_pkg::pcfg_kind_t       kind;
  logic [3:0]                 idx;
  logic                       access, firstAcc, commit, cfgWin, refuse;
  logic [31:0]                rdVal;
  logic [2:0]                 newMode;

  pcfg_link_if lnk ();

  function automatic pcfg_pkg::pcfg_kind_t decodeKind(input logic [11:0] a);
    decodeKind = pcfg_pkg::K_NONE;
    if (a[1:0] == 2'h0)
    begin
      if (a == pcfg_pkg::OFS_STAT)
        decodeKind = pcfg_pkg::K_STAT;
      else if (a == pcfg_pkg::OFS_CTRL)
        decodeKind = pcfg_pkg::K_CTRL;
      else if (a[11:4] == pcfg_pkg::OFS_TMR[11:4])
        decodeKind = pcfg_pkg::K_TMR;
      else if (a[11:4] == pcfg_pkg::OFS_PARTITION_SELECT[11:4])
        decodeKind = pcfg_pkg::K_PARTITION_SELECT;
      else if (a[11:6] == pcfg_pkg::OFS_PORT[11:6])
        decodeKind = pcfg_pkg::K_PORT;
      else if (a[11:6] == pcfg_pkg::OFS_PHY[11:6])
        decodeKind = pcfg_pkg::K_PHY;
      else if (a[11:6] == pcfg_pkg::OFS_CAP[11:6])
        decodeKind = pcfg_pkg::K_CAP;
    end
  endfunction : decodeKind

  // boot default mode of a port when no eeprom load is selected
  function automatic logic [2:0] bootMode(input int n, input logic [3:0] sw);
    if (sw == pcfg_pkg::SWITCH_MODE_VECTOR_MULTI_EE)
      bootMode = pcfg_pkg::MODE_UNATT;
    else if (n == 0)
      bootMode = pcfg_pkg::MODE_UP;
    else
      bootMode = pcfg_pkg::MODE_DOWN;
  endfunction : bootMode

  // every pin input passes two flops before use
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      modeS1_q <= 4'h0;
      modeS2_q <= 4'h0;
      frS1_q   <= 1'b1; // idle level: no reload from a half-filled vector
      frS2_q   <= 1'b1;
      prsS1_q  <= '0;
      prsS2_q  <= '0;
      prtS1_q  <= '1;
      prtS2_q  <= '1;
    end
    else
    begin
      modeS1_q <= switchModePin;
      modeS2_q <= modeS1_q;
      frS1_q   <= fundResetPinN;
      frS2_q   <= frS1_q;
      prsS1_q  <= partnerPresent;
      prsS2_q  <= prsS1_q;
      prtS1_q  <= partResetPinN;
      prtS2_q  <= prtS1_q;
    end
  end

  // bus decode; address, direction and data stay put through the access
  assign kind     = decodeKind(paddr);
  assign idx      = paddr[5:2];
  assign access   = psel && penable;
  assign firstAcc = access && !pready && !busy_q;
  assign commit   = access && pready && pwrite && !pslverr;
  assign cfgWin   = frS2_q && configOpen;
  assign refuse   = pwrite && !cfgWin
                    && (kind == pcfg_pkg::K_PARTITION_SELECT || kind == pcfg_pkg::K_PORT);
  assign newMode  = pwdata[pcfg_pkg::PC_MODE +: 3];

  // boot vector follows the mode pins while the fundamental reset pin is low, and is held once it rises
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      switch_mode_vector_q   <= 4'h0;
      configOpen <= 1'b0;
      rstEn_q    <= 1'b0;
    end
    else if (!frS2_q)
    begin
      switch_mode_vector_q   <= modeS2_q;
      configOpen <= 1'b1;
      rstEn_q    <= 1'b0;
    end
    else if (commit && kind == pcfg_pkg::K_CTRL)
    begin
      if (pwdata[pcfg_pkg::CTRL_DONE])
        configOpen <= 1'b0;
      rstEn_q <= pwdata[pcfg_pkg::CTRL_RSTEN];
    end
  end

  // read data view of the block state
  always_comb
  begin
    rdVal = 32'h0000_0000;
    case (kind)
      pcfg_pkg::K_STAT:
      begin
        rdVal[3:0]                = switch_mode_vector_q;
        rdVal[pcfg_pkg::STAT_OPEN] = cfgWin;
      end
      pcfg_pkg::K_CTRL:
        rdVal[pcfg_pkg::CTRL_RSTEN] = rstEn_q;
      pcfg_pkg::K_TMR:
        rdVal[pcfg_pkg::TMR_W-1:0] = tmr_q[idx[1:0]];
      pcfg_pkg::K_PARTITION_SELECT:
        rdVal[1:0] = partSt_q[idx[1:0]];
      pcfg_pkg::K_PORT:
      begin
        rdVal[pcfg_pkg::PC_MODE +: 3]             = portMode_q[idx];
        rdVal[pcfg_pkg::PC_PSEL +: pcfg_pkg::PSW] = portPart_q[idx];
        rdVal[pcfg_pkg::PC_OMA +: 3]              = portOma_q[idx];
      end
      pcfg_pkg::K_PHY:
      begin
        rdVal[pcfg_pkg::PHY_LS +: 2] = lnk.ltssm[idx];
        rdVal[pcfg_pkg::PHY_UP]      = lnk.linkUp[idx];
      end
      pcfg_pkg::K_CAP:
        rdVal[19:0] = cap_q[idx];
      default:
        rdVal = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait state, or until the mode-change drain ends
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      busy_q  <= 1'b0;
    end
    else if (pready)
      pready <= 1'b0;
    else if (busy_q)
    begin
      if (drainDone)
      begin
        busy_q <= 1'b0;
        pready <= 1'b1;
      end
    end
    else if (firstAcc)
    begin
      pslverr <= (kind == pcfg_pkg::K_NONE) || refuse;
      prdata  <= pwrite ? 32'h0000_0000 : rdVal;
      if (pwrite && kind == pcfg_pkg::K_PORT && !refuse)
        busy_q <= 1'b1; // queued traffic drains before the mode moves
      else
        pready <= 1'b1;
    end
  end

  pcfg_drain u_drain (
    .clk    (clk),
    .resetn (resetn),
    .start  (firstAcc && pwrite && kind == pcfg_pkg::K_PORT && !refuse),
    .units  (tmr_q[pcfg_pkg::TMR_MC]),
    .done   (drainDone)
  );

  // partition states, reloaded from the boot vector during reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < pcfg_pkg::NPART; p++)
        partSt_q[p] <= pcfg_pkg::PST_DIS;
    end
    else if (!frS2_q)
    begin
      for (int p = 0; p < pcfg_pkg::NPART; p++)
        partSt_q[p] <= (p == 0 && modeS2_q != pcfg_pkg::SWITCH_MODE_VECTOR_MULTI_EE)
                       ? pcfg_pkg::PST_ACT : pcfg_pkg::PST_DIS;
    end
    else if (commit && kind == pcfg_pkg::K_PARTITION_SELECT)
      partSt_q[idx[1:0]] <= pwdata[1:0];
  end

  // port mode, partition and action; other port registers untouched
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int n = 0; n < pcfg_pkg::NPORT; n++)
      begin
        portMode_q[n] <= pcfg_pkg::MODE_UNATT;
        portPart_q[n] <= '0;
        portOma_q[n]  <= pcfg_pkg::OMA_NONE;
      end
      modeChg_q <= '0;
    end
    else
    begin
      modeChg_q <= '0;
      if (!frS2_q)
      begin
        for (int n = 0; n < pcfg_pkg::NPORT; n++)
        begin
          portMode_q[n] <= bootMode(n, modeS2_q);
          portPart_q[n] <= '0;
          portOma_q[n]  <= pcfg_pkg::OMA_NONE;
        end
      end
      else if (commit && kind == pcfg_pkg::K_PORT)
      begin
        portMode_q[idx] <= newMode;
        portOma_q[idx]  <= pwdata[pcfg_pkg::PC_OMA +: 3];
        if (newMode != pcfg_pkg::MODE_DIS)
          portPart_q[idx] <= pwdata[pcfg_pkg::PC_PSEL +: pcfg_pkg::PSW];
        modeChg_q[idx] <= 1'b1;
      end
    end
  end

  // full-link-retrain bit acts as a one-cycle command and reads back zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      retrain_q <= '0;
    else
    begin
      retrain_q <= '0;
      if (commit && kind == pcfg_pkg::K_PHY)
        retrain_q[idx] <= pwdata[pcfg_pkg::PHY_FULL_LINK_RETRAIN];
    end
  end

  // delay timers and capability next pointers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int t = 0; t < pcfg_pkg::NTMR; t++)
        tmr_q[t] <= pcfg_pkg::TMR_RST[t];
      for (int n = 0; n < pcfg_pkg::NPORT; n++)
        cap_q[n] <= 20'h00000;
    end
    else if (commit && kind == pcfg_pkg::K_TMR)
      tmr_q[idx[1:0]] <= pwdata[pcfg_pkg::TMR_W-1:0];
    else if (commit && kind == pcfg_pkg::K_CAP)
    begin
      cap_q[idx][pcfg_pkg::CAP_PM_W-1:0]           <= pwdata[pcfg_pkg::CAP_PM_W-1:0];
      cap_q[idx][pcfg_pkg::CAP_VC +: pcfg_pkg::CAP_VC_W] <=
        pwdata[pcfg_pkg::CAP_VC +: pcfg_pkg::CAP_VC_W];
    end
  end

  // partition status outputs; reset pins count only once enabled
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      partActive      <= '0;
      partResetActive <= '0;
      portLinkUp      <= '0;
    end
    else
    begin
      for (int p = 0; p < pcfg_pkg::NPART; p++)
      begin
        partActive[p]      <= (partSt_q[p] == pcfg_pkg::PST_ACT);
        partResetActive[p] <= rstEn_q && !prtS2_q[p];
      end
      portLinkUp <= lnk.linkUp;
    end
  end

  // a port trains only when attached, operational and its partition is live
  always_comb
  begin
    for (int n = 0; n < pcfg_pkg::NPORT; n++)
    begin
      lnk.operational[n] = (portMode_q[n] == pcfg_pkg::MODE_UP
                            || portMode_q[n] == pcfg_pkg::MODE_DOWN)
                           && partSt_q[portPart_q[n]] == pcfg_pkg::PST_ACT
                           && !(rstEn_q && !prtS2_q[portPart_q[n]]);
      lnk.upDir[n] = (portMode_q[n] == pcfg_pkg::MODE_UP);
    end
    lnk.retrain = retrain_q;
    lnk.modeChg = modeChg_q;
    lnk.present = prsS2_q;
  end

  pcfg_link_train u_train (
    .clk    (clk),
    .resetn (resetn),
    .lnk    (lnk)
  );
endmodule : pcfg_top
`default_nettype wire

// ===== include/pcfg_pkg.sv
`default_nettype none
package pcfg_pkg;
  // sizes
  localparam int NPORT = 16;
  localparam int NPART = 4;
  localparam int PSW   = 2;
  localparam int NTMR  = 4;
  localparam int TMR_W = 16;
  // boot switch-mode code for multi-partition with serial eeprom load
  localparam logic [3:0] SWITCH_MODE_VECTOR_MULTI_EE = 4'hd;
  // port operating modes and mode-change actions
  localparam logic [2:0] MODE_UNATT = 3'h0;
  localparam logic [2:0] MODE_DOWN  = 3'h1;
  localparam logic [2:0] MODE_UP    = 3'h2;
  localparam logic [2:0] MODE_DIS   = 3'h3;
  localparam logic [2:0] OMA_NONE   = 3'h0;
  // partition states
  localparam logic [1:0] PST_DIS = 2'h0;
  localparam logic [1:0] PST_ACT = 2'h1;
  // register byte offsets
  localparam logic [11:0] OFS_STAT = 12'h000;
  localparam logic [11:0] OFS_CTRL = 12'h004;
  localparam logic [11:0] OFS_TMR  = 12'h010;
  localparam logic [11:0] OFS_PARTITION_SELECT = 12'h020;
  localparam logic [11:0] OFS_PORT = 12'h040;
  localparam logic [11:0] OFS_PHY  = 12'h080;
  localparam logic [11:0] OFS_CAP  = 12'h0c0;
  // field positions
  localparam int STAT_OPEN  = 8;
  localparam int CTRL_DONE  = 0;
  localparam int CTRL_RSTEN = 1;
  localparam int PC_MODE    = 0;
  localparam int PC_PSEL    = 4;
  localparam int PC_OMA     = 8;
  localparam int PHY_FULL_LINK_RETRAIN  = 0;
  localparam int PHY_LS     = 4;
  localparam int PHY_UP     = 8;
  localparam int CAP_PM_W   = 8;
  localparam int CAP_VC_W   = 12;
  localparam int CAP_VC     = 8;
  // timer slots and their reset values, in microsecond units
  localparam int TMR_SE  = 0;
  localparam int TMR_MC  = 1;
  localparam int TMR_RD  = 2;
  localparam int TMR_SBR = 3;
  localparam logic [TMR_W-1:0] TMR_RST [NTMR] = '{16'h0064, 16'h07d0, 16'h07d0, 16'h0064};
  // timing
  localparam int CLK_NS      = 4;
  localparam int TMR_UNIT_NS = 1000;
  localparam int TICK_CYC    = TMR_UNIT_NS / CLK_NS;
  localparam int TRAIN_NS    = 24;
  localparam int TRAIN_CYC   = (TRAIN_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {K_NONE, K_STAT, K_CTRL, K_TMR, K_PARTITION_SELECT, K_PORT, K_PHY, K_CAP} pcfg_kind_t;
  typedef enum logic [1:0] {LS_OFF, LS_DETECT, LS_POLL, LS_L0} pcfg_lstate_t;
endpackage : pcfg_pkg
`default_nettype wire

// ===== include/pcfg_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pcfg_link_if;
  logic [pcfg_pkg::NPORT-1:0] operational;
  logic [pcfg_pkg::NPORT-1:0] upDir;
  logic [pcfg_pkg::NPORT-1:0] retrain;
  logic [pcfg_pkg::NPORT-1:0] modeChg;
  logic [pcfg_pkg::NPORT-1:0] present;
  logic [pcfg_pkg::NPORT-1:0] linkUp;
  pcfg_pkg::pcfg_lstate_t     ltssm [pcfg_pkg::NPORT];
  modport ctl (output operational, upDir, retrain, modeChg, present, input linkUp, ltssm);
  modport trn (input operational, upDir, retrain, modeChg, present, output linkUp, ltssm);
endinterface : pcfg_link_if
`default_nettype wire

// ===== hw/pcfg_drain.sv
`timescale 1ns/100ps
`default_nettype none
module pcfg_drain (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        start,
  input  wire logic [pcfg_pkg::TMR_W-1:0]  units,
  output var  logic                        done
);
  logic [pcfg_pkg::TMR_W-1:0] remain_q;
  logic [7:0]                 tick_q;
  logic                       run_q;

  // microsecond enable from a divider, counted down only while draining
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      remain_q <= '0;
      tick_q   <= 8'h00;
      run_q    <= 1'b0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        tick_q   <= 8'h00;
        remain_q <= units;
        run_q    <= (units != '0);
        done     <= (units == '0); // zeroed timer: no drain wait
      end
      else if (run_q)
      begin
        if (tick_q == 8'(pcfg_pkg::TICK_CYC - 1))
        begin
          tick_q   <= 8'h00;
          remain_q <= remain_q - 1'b1;
          if (remain_q == 16'h0001)
          begin
            run_q <= 1'b0;
            done  <= 1'b1;
          end
        end
        else
          tick_q <= tick_q + 1'b1;
      end
    end
  end
endmodule : pcfg_drain
`default_nettype wire

// ===== hw/pcfg_link_train.sv
`timescale 1ns/100ps
`default_nettype none
module pcfg_link_train (
  input  wire logic   clk,
  input  wire logic   resetn,
  pcfg_link_if.trn    lnk
);
  pcfg_pkg::pcfg_lstate_t st_q  [pcfg_pkg::NPORT];
  logic [2:0]             cnt_q [pcfg_pkg::NPORT];
  logic [pcfg_pkg::NPORT-1:0] dir_q;

  // simplified per-port training: detect, poll for a fixed time, then up
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int n = 0; n < pcfg_pkg::NPORT; n++)
      begin
        st_q[n]  <= pcfg_pkg::LS_OFF;
        cnt_q[n] <= 3'h0;
      end
      dir_q      <= '0;
      lnk.linkUp <= '0;
    end
    else
    begin
      for (int n = 0; n < pcfg_pkg::NPORT; n++)
      begin
        lnk.linkUp[n] <= (st_q[n] == pcfg_pkg::LS_L0);
        if (!lnk.operational[n])
          st_q[n] <= pcfg_pkg::LS_OFF;
        else if (lnk.retrain[n])
          st_q[n] <= pcfg_pkg::LS_DETECT;
        else if (lnk.modeChg[n] && st_q[n] != pcfg_pkg::LS_L0)
        begin
          st_q[n]  <= pcfg_pkg::LS_DETECT;
          dir_q[n] <= lnk.upDir[n];
        end
        else
        begin
          case (st_q[n])
            pcfg_pkg::LS_OFF:
            begin
              st_q[n]  <= pcfg_pkg::LS_DETECT;
              dir_q[n] <= lnk.upDir[n];
            end
            pcfg_pkg::LS_DETECT:
            begin
              cnt_q[n] <= 3'h0;
              if (lnk.present[n])
                st_q[n] <= pcfg_pkg::LS_POLL;
            end
            pcfg_pkg::LS_POLL:
              if (!lnk.present[n])
                st_q[n] <= pcfg_pkg::LS_DETECT;
              else if (cnt_q[n] == 3'(pcfg_pkg::TRAIN_CYC - 1))
                st_q[n] <= pcfg_pkg::LS_L0;
              else
                cnt_q[n] <= cnt_q[n] + 1'b1;
            pcfg_pkg::LS_L0:
              if (!lnk.present[n])
                st_q[n] <= pcfg_pkg::LS_DETECT;
            default:
              st_q[n] <= pcfg_pkg::LS_OFF;
          endcase
        end
      end
    end
  end

  always_comb
  begin
    for (int n = 0; n < pcfg_pkg::NPORT; n++)
      lnk.ltssm[n] = st_q[n];
  end
endmodule : pcfg_link_train
`default_nettype wire

// ===== tb/pcfg_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module pcfg_assertions (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  switchModePin,
  input wire logic        fundResetPinN,
  input wire logic [15:0] partnerPresent,
  input wire logic [3:0]  partResetPinN,
  input wire logic [15:0] portLinkUp,
  input wire logic [3:0]  partActive,
  input wire logic [3:0]  partResetActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // completion edge of an apb transfer
  wire logic accEnd = psel && penable && pready;
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  chk_read_wait: assert property (psel && penable && !pwrite && !pready |=> pready)
    else $error("read not answered after one wait cycle");
  chk_unmapped_err: assert property (accEnd && (paddr >= 12'h100 || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_timer_ok: assert property (accEnd && paddr[11:4] == 8'h01 && paddr[1:0] == 2'h0
    |-> !pslverr)
    else $error("timer access refused");
  // pin is synchronised, so it must have been low for a while
  chk_window_shut: assert property (!fundResetPinN[*4] ##0 (accEnd && pwrite
    && paddr[11:4] == 8'h02) |-> pslverr)
    else $error("partition write accepted during reset");
  chk_boot_empty: assert property ((!fundResetPinN
    && switchModePin == pcfg_pkg::SWITCH_MODE_VECTOR_MULTI_EE)[*5] |=> partActive == 4'h0)
    else $error("partition active after eeprom boot");
  chk_boot_default: assert property ((!fundResetPinN
    && switchModePin != pcfg_pkg::SWITCH_MODE_VECTOR_MULTI_EE)[*6] |=> partActive == 4'h1)
    else $error("default boot partitions wrong");
  chk_no_partner: assert property ((partnerPresent == 16'h0)[*8] |-> portLinkUp == 16'h0)
    else $error("link up with no partner");
  chk_pin_idle: assert property ((partResetPinN == 4'hf)[*5] |-> partResetActive == 4'h0)
    else $error("partition reset without pin");
  cover property (accEnd && pslverr);
  cover property ($fell(portLinkUp[1]));
  cover property ($rose(partResetActive[1]));
endmodule : pcfg_assertions
bind pcfg_top pcfg_assertions chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .switchModePin(switchModePin), .fundResetPinN(fundResetPinN),
  .partnerPresent(partnerPresent), .partResetPinN(partResetPinN), .portLinkUp(portLinkUp),
  .partActive(partActive), .partResetActive(partResetActive));
`default_nettype wire

// ===== tb/pcfg_cfg_master.sv
`timescale 1ns/100ps
`default_nettype none
module pcfg_cfg_master (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  int loadErrs = 0;
  // bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one whole transfer; an idle cycle follows so callers may chain calls
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    if (e !== 1'b0)
      loadErrs++;
  endtask : wr
  // port control word with no-action change
  function automatic logic [31:0] pv(input logic [2:0] m, input logic [1:0] p);
    return {21'h0, pcfg_pkg::OMA_NONE, 2'h0, p, 1'b0, m};
  endfunction : pv
  // two partitions: up 0, down 1-2; up 3, down 4-5; the rest disabled
  task automatic load();
    for (int t = 0; t < 4; t++)
      wr(pcfg_pkg::OFS_TMR + 12'(4 * t), 32'h0);
    wr(pcfg_pkg::OFS_PARTITION_SELECT, 32'h1);
    wr(pcfg_pkg::OFS_PARTITION_SELECT + 12'h004, 32'h1);
    for (int n = 1; n < 6; n++)
      if (n != 3)
      begin
        wr(pcfg_pkg::OFS_PORT + 12'(4 * n), pv(pcfg_pkg::MODE_DOWN, 2'(n / 4)));
        wr(pcfg_pkg::OFS_PHY + 12'(4 * n), 32'h1);
      end
    wr(pcfg_pkg::OFS_PORT, pv(pcfg_pkg::MODE_UP, 2'h0));
    wr(pcfg_pkg::OFS_PORT + 12'h00c, pv(pcfg_pkg::MODE_UP, 2'h1));
    // partition field deliberately varied: it must not matter here
    for (int n = 6; n < 16; n++)
      wr(pcfg_pkg::OFS_PORT + 12'(4 * n), pv(pcfg_pkg::MODE_DIS, 2'(n)));
    wr(pcfg_pkg::OFS_CAP, 32'h00010070);
    wr(pcfg_pkg::OFS_CAP + 12'h00c, 32'h00010070);
    wr(pcfg_pkg::OFS_CTRL, 32'h2);
    for (int t = 0; t < 4; t++)
      wr(pcfg_pkg::OFS_TMR + 12'(4 * t), 32'(pcfg_pkg::TMR_RST[t]));
  endtask : load
endmodule : pcfg_cfg_master
`default_nettype wire

// ===== tb/partition_port_static_config_test.sv
`timescale 1ns/100ps
`default_nettype none
module partition_port_static_config_test;
  logic        clk;
  logic        resetn;
  logic        fundResetPinN;
  logic [3:0]  switchModePin;
  logic [15:0] partnerPresent;
  logic [3:0]  partResetPinN;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] portLinkUp;
  logic [3:0]  partActive;
  logic [3:0]  partResetActive;
  logic        configOpen;
  logic [31:0] rdv;
  logic        err;
  int          failures = 0;
  int          compares = 0;
  pcfg_top dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switchModePin(switchModePin), .fundResetPinN(fundResetPinN),
    .partnerPresent(partnerPresent), .partResetPinN(partResetPinN), .portLinkUp(portLinkUp),
    .partActive(partActive), .partResetActive(partResetActive), .configOpen(configOpen));
  pcfg_cfg_master cm (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // 4 ns clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    cm.xfer(1'b0, a, 32'h0, rdv, err);
    check({rdv & m, 31'h0, err}, {x, 32'h0});
  endtask : rd
  // training takes a variable number of cycles, so poll with a limit
  task waitFor(input logic [15:0] x, input int lim);
    for (int i = 0; i < lim && portLinkUp !== x; i++)
      @(posedge clk);
    check(portLinkUp, x);
  endtask : waitFor
  task stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    failures++;
    stop_test;
  end
  initial
  begin
    resetn = 1'b0;
    fundResetPinN = 1'b0;
    switchModePin = pcfg_pkg::SWITCH_MODE_VECTOR_MULTI_EE;
    partnerPresent = 16'h0;
    partResetPinN = 4'hf;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    check(partActive, 4'h0);
    check(configOpen, 1'b1);
    cm.xfer(1'b1, pcfg_pkg::OFS_PARTITION_SELECT, 32'h1, rdv, err);
    check(err, 1'b1);
    fundResetPinN <= 1'b1;
    partnerPresent <= 16'h00bf;
    repeat (4) @(posedge clk);
    cm.load();
    check(cm.loadErrs, 0);
    check(partActive, 4'h3);
    rd(pcfg_pkg::OFS_PORT + 12'h004, 32'h7ff, cm.pv(pcfg_pkg::MODE_DOWN, 2'h0));
    rd(pcfg_pkg::OFS_PORT + 12'h00c, 32'h7ff, cm.pv(pcfg_pkg::MODE_UP, 2'h1));
    for (int n = 6; n < 16; n++)
      rd(pcfg_pkg::OFS_PORT + 12'(4 * n), 32'h737, 32'(pcfg_pkg::MODE_DIS));
    for (int t = 0; t < 4; t++)
      rd(pcfg_pkg::OFS_TMR + 12'(4 * t), 32'hffff, 32'(pcfg_pkg::TMR_RST[t]));
    rd(pcfg_pkg::OFS_CAP + 12'h00c, 32'hfffff, 32'h00010070);
    rd(pcfg_pkg::OFS_STAT, 32'h10f, 32'h10d);
    cm.xfer(1'b0, 12'h100, 32'h0, rdv, err);
    check({rdv, 31'h0, err}, 64'h1);
    cm.xfer(1'b1, 12'h012, 32'h0, rdv, err);
    check(err, 1'b1);
    // later port writes must not wait out the restored drain time
    cm.wr(pcfg_pkg::OFS_TMR + 12'h004, 32'h0);
    waitFor(16'h003f, 300);
    rd(pcfg_pkg::OFS_PHY + 12'h004, 32'h131, 32'h130);
    cm.wr(pcfg_pkg::OFS_PHY + 12'h004, 32'h1);
    waitFor(16'h003d, 12);
    waitFor(16'h003f, 60);
    cm.wr(pcfg_pkg::OFS_PORT + 12'h008, cm.pv(pcfg_pkg::MODE_UP, 2'h0));
    // looked at soon, before a wrongly retrained link could come back up
    repeat (4) @(posedge clk);
    check(portLinkUp, 16'h003f);
    rd(pcfg_pkg::OFS_PORT + 12'h008, 32'h7ff, cm.pv(pcfg_pkg::MODE_UP, 2'h0));
    cm.wr(pcfg_pkg::OFS_PORT + 12'h01c, cm.pv(pcfg_pkg::MODE_DOWN, 2'h1));
    waitFor(16'h00bf, 60);
    partResetPinN <= 4'hd;
    waitFor(16'h0007, 30);
    check(partResetActive, 4'h2);
    partResetPinN <= 4'hf;
    waitFor(16'h00bf, 60);
    cm.wr(pcfg_pkg::OFS_CTRL, 32'h3);
    check(configOpen, 1'b0);
    cm.xfer(1'b1, pcfg_pkg::OFS_PORT + 12'h020, 32'h1, rdv, err);
    check(err, 1'b1);
    partnerPresent <= 16'h0;
    waitFor(16'h0, 30);
    switchModePin <= 4'h0;
    @(posedge clk);
    fundResetPinN <= 1'b0;
    repeat (10) @(posedge clk);
    check(partActive, 4'h1);
    check(configOpen, 1'b1);
    stop_test;
  end
endmodule : partition_port_static_config_test
`default_nettype wire
